// ==== core/itrc_defs.svh ====
// Purpose: Constants of the interval timer / RTC counter: offsets, fields,
//          reset values and timing counts.
// Assumes: 32-bit APB, one aligned word per register.
// Notes:   Definitions only.
`ifndef ITRC_DEFS_SVH
`define ITRC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ITRC_OFS_CONTROL    12'h000
`define ITRC_OFS_COUNT      12'h004
`define ITRC_OFS_STATUS     12'h008

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define ITRC_BIT_RUN        15
`define ITRC_BIT_HALT_IDLE  13
`define ITRC_BIT_GATE_EN    6
`define ITRC_BIT_PRESC_HI   5
`define ITRC_BIT_PRESC_LO   4
`define ITRC_BIT_SYNC_SEL   2
`define ITRC_BIT_CLK_SRC    1

// ----------------------------------------------------------------------
// Reset values and implemented control bit mask
// ----------------------------------------------------------------------
`define ITRC_RST_CONTROL    16'h0000
`define ITRC_RST_COUNT      16'h0000
`define ITRC_MASK_CONTROL   16'hA076

// ----------------------------------------------------------------------
// Prescale terminal counts (ratio minus one)
// ----------------------------------------------------------------------
`define ITRC_TERM_DIV1      8'h00
`define ITRC_TERM_DIV8      8'h07
`define ITRC_TERM_DIV64     8'h3F
`define ITRC_TERM_DIV256    8'hFF

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define ITRC_SYNC_DEPTH     3
`define ITRC_POST_SYNC      2

`endif

// ==== core/itrc_pkg.sv ====
// Purpose: Types of the interval timer / RTC counter.
// Assumes: Constants come from itrc_defs.svh.
// Notes:   Mode codes walk a Gray path timer-gated-sync-async.
`default_nettype none
package itrc_pkg;

  // --------------------------------------------------------------------
  // Operating mode
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ITRC_MODE_TIMER = 2'h0,
    ITRC_MODE_GATED = 2'h1,
    ITRC_MODE_SYNC  = 2'h3,
    ITRC_MODE_ASYNC = 2'h2
  } itrc_mode_type;

  // --------------------------------------------------------------------
  // Register selection
  // --------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ITRC_SEL_NONE    = 2'h0,
    ITRC_SEL_CONTROL = 2'h1,
    ITRC_SEL_COUNT   = 2'h3,
    ITRC_SEL_STATUS  = 2'h2
  } itrc_sel_type;

  // --------------------------------------------------------------------
  // Prescaler state
  // --------------------------------------------------------------------
  typedef struct packed
  {
    logic [7:0] count;
    logic       pulse;
  } itrc_presc_state_type;

  // --------------------------------------------------------------------
  // Timer state
  // --------------------------------------------------------------------
  typedef struct packed
  {
    logic        run;
    logic        halt_idle;
    logic        gate_en;
    logic [1:0]  presc;
    logic        sync_sel;
    logic        clk_src;
    logic [15:0] count;
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic        ext_edge;
    logic [2:0]  gate_sync;
    logic        gate_level;
    logic [1:0]  post_sync;
    logic [31:0] prdata;
    logic        slverr;
  } itrc_state_type;

endpackage
`default_nettype wire

// ==== core/itrc_prescaler.sv ====
// Purpose: Divides a stream of count ticks by 1, 8, 64 or 256.
// Assumes: tick_in is a one-cycle pulse on clk_sys.
// Notes:   pulse_out is registered, one cycle after the terminal tick.
`timescale 1ns/1ps
`default_nettype none
`include "itrc_defs.svh"

module itrc_prescaler
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Control
  input  wire logic       clear,
  input  wire logic [1:0] prescale_select,
  // Ticks
  input  wire logic       tick_in,
  output logic            pulse_out
);
  import itrc_pkg::*;

  itrc_presc_state_type state_reg;
  itrc_presc_state_type state_next;

  function automatic logic [7:0] term_of(input logic [1:0] sel);
    case (sel)
      2'h3:    term_of = `ITRC_TERM_DIV256;
      2'h2:    term_of = `ITRC_TERM_DIV64;
      2'h1:    term_of = `ITRC_TERM_DIV8;
      default: term_of = `ITRC_TERM_DIV1;
    endcase
  endfunction

  always_comb
  begin
    state_next       = state_reg;
    state_next.pulse = 1'b0;
    if (clear)
    begin
      state_next.count = 8'h00;
    end
    else if (tick_in)
    begin
      // One output pulse per ratio input ticks
      if (state_reg.count >= term_of(prescale_select))
      begin
        state_next.count = 8'h00;
        state_next.pulse = 1'b1;
      end
      else
      begin
        state_next.count = state_reg.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign pulse_out = state_reg.pulse;

endmodule
`default_nettype wire

// ==== core/itrc_timer.sv ====
// Purpose: 16-bit interval timer / RTC time-base counter behind APB.
// Assumes: clk_sys is the instruction cycle clock; pins are asynchronous.
// Notes:   One clock domain; external edges are sampled, then prescaled.
`timescale 1ns/1ps
`default_nettype none
`include "itrc_defs.svh"

module itrc_timer
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pins
  input  wire logic        external_count_pin,
  input  wire logic        gate_pin,
  // Device state
  input  wire logic        idle_mode,
  // Observation
  output itrc_pkg::itrc_mode_type mode,
  output logic [15:0]      count_value
);
  import itrc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  itrc_state_type state_reg;
  itrc_state_type state_next;

  logic         presc_pulse;
  logic         presc_clear;
  logic         tick_in;
  logic         count_tick;
  logic         stall;
  logic         gate_open;
  logic         setup_phase;
  logic         access_wr;
  logic         ctrl_we;
  logic         cnt_we;
  itrc_sel_type setup_sel;
  itrc_sel_type access_sel;
  logic [15:0]  ctrl_word;
  logic [15:0]  status_word;
  logic [15:0]  wr_merge_ctrl;
  logic [15:0]  wr_merge_cnt;

  // ----------------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------------
  function automatic itrc_sel_type sel_of(input logic [11:0] addr);
    case (addr)
      `ITRC_OFS_CONTROL: sel_of = ITRC_SEL_CONTROL;
      `ITRC_OFS_COUNT:   sel_of = ITRC_SEL_COUNT;
      `ITRC_OFS_STATUS:  sel_of = ITRC_SEL_STATUS;
      default:           sel_of = ITRC_SEL_NONE;
    endcase
  endfunction

  function automatic logic [15:0] merge_lanes(input logic [15:0] old_val,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb);
    merge_lanes = old_val;
    if (strb[0])
    begin
      merge_lanes[7:0] = wdata[7:0];
    end
    if (strb[1])
    begin
      merge_lanes[15:8] = wdata[15:8];
    end
  endfunction

  assign setup_sel  = sel_of(paddr);
  assign access_sel = sel_of(paddr);

  // Zero wait states: the read word is latched in the setup cycle
  assign pready      = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_wr   = psel && penable && pwrite && pready;
  assign ctrl_we     = access_wr && (access_sel == ITRC_SEL_CONTROL);
  assign cnt_we      = access_wr && (access_sel == ITRC_SEL_COUNT);

  // ----------------------------------------------------------------------
  // Register views
  // ----------------------------------------------------------------------
  always_comb
  begin
    ctrl_word                      = 16'h0000;
    ctrl_word[`ITRC_BIT_RUN]       = state_reg.run;
    ctrl_word[`ITRC_BIT_HALT_IDLE] = state_reg.halt_idle;
    ctrl_word[`ITRC_BIT_GATE_EN]   = state_reg.gate_en;
    ctrl_word[`ITRC_BIT_PRESC_HI]  = state_reg.presc[1];
    ctrl_word[`ITRC_BIT_PRESC_LO]  = state_reg.presc[0];
    ctrl_word[`ITRC_BIT_SYNC_SEL]  = state_reg.sync_sel;
    ctrl_word[`ITRC_BIT_CLK_SRC]   = state_reg.clk_src;
  end

  assign status_word   = {11'h000, state_reg.ext_level, state_reg.gate_level,
                          !stall, mode};
  assign wr_merge_ctrl = merge_lanes(ctrl_word, pwdata, pstrb) & `ITRC_MASK_CONTROL;
  assign wr_merge_cnt  = merge_lanes(state_reg.count, pwdata, pstrb);

  // ----------------------------------------------------------------------
  // Mode and count source
  // ----------------------------------------------------------------------
  // Gate bit only matters on the internal clock, sync bit only on external
  always_comb
  begin
    if (!state_reg.clk_src)
    begin
      mode = state_reg.gate_en ? ITRC_MODE_GATED : ITRC_MODE_TIMER;
    end
    else
    begin
      mode = state_reg.sync_sel ? ITRC_MODE_SYNC : ITRC_MODE_ASYNC;
    end
  end

  assign stall     = !state_reg.run || (state_reg.halt_idle && idle_mode);
  assign gate_open = (mode != ITRC_MODE_GATED) || state_reg.gate_level;

  always_comb
  begin
    case (mode)
      ITRC_MODE_TIMER: tick_in = !stall;
      ITRC_MODE_GATED: tick_in = !stall && gate_open;
      ITRC_MODE_SYNC:  tick_in = !stall && state_reg.ext_edge;
      ITRC_MODE_ASYNC: tick_in = !stall && state_reg.ext_edge;
      default:         tick_in = 1'b0;
    endcase
  end

  // A control write restarts the division so a new ratio starts cleanly
  assign presc_clear = !state_reg.run || ctrl_we;

  itrc_prescaler u_prescaler
  (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .clear           (presc_clear),
    .prescale_select (state_reg.presc),
    .tick_in         (tick_in),
    .pulse_out       (presc_pulse)
  );

  // Sync mode retimes the divided pulse; async uses it as it comes
  always_comb
  begin
    case (mode)
      ITRC_MODE_SYNC:  count_tick = state_reg.run && state_reg.post_sync[1];
      ITRC_MODE_ASYNC: count_tick = state_reg.run && presc_pulse;
      default:         count_tick = state_reg.run && presc_pulse;
    endcase
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;

    // Pin sampling: a rising edge counts when stages two and three agree
    state_next.ext_sync  = {state_reg.ext_sync[1:0], external_count_pin};
    state_next.gate_sync = {state_reg.gate_sync[1:0], gate_pin};
    state_next.ext_edge  = 1'b0;
    if (state_reg.ext_sync[1] == state_reg.ext_sync[2])
    begin
      state_next.ext_level = state_reg.ext_sync[2];
      state_next.ext_edge  = state_reg.ext_sync[2] && !state_reg.ext_level;
    end
    if (state_reg.gate_sync[1] == state_reg.gate_sync[2])
    begin
      state_next.gate_level = state_reg.gate_sync[2];
    end

    // Post-prescaler alignment stage
    if (mode == ITRC_MODE_SYNC)
    begin
      state_next.post_sync = {state_reg.post_sync[0], presc_pulse};
    end
    else
    begin
      state_next.post_sync = 2'h0;
    end

    // Counter: a software write wins over a tick in the same cycle
    if (cnt_we)
    begin
      state_next.count = wr_merge_cnt;
    end
    else if (count_tick)
    begin
      state_next.count = state_reg.count + 16'h0001;
    end

    if (ctrl_we)
    begin
      state_next.run       = wr_merge_ctrl[`ITRC_BIT_RUN];
      state_next.halt_idle = wr_merge_ctrl[`ITRC_BIT_HALT_IDLE];
      state_next.gate_en   = wr_merge_ctrl[`ITRC_BIT_GATE_EN];
      state_next.presc     = wr_merge_ctrl[`ITRC_BIT_PRESC_HI:`ITRC_BIT_PRESC_LO];
      state_next.sync_sel  = wr_merge_ctrl[`ITRC_BIT_SYNC_SEL];
      state_next.clk_src   = wr_merge_ctrl[`ITRC_BIT_CLK_SRC];
    end

    // Read data and error are latched in the setup cycle
    if (setup_phase)
    begin
      state_next.slverr = (setup_sel == ITRC_SEL_NONE);
      case (setup_sel)
        ITRC_SEL_CONTROL: state_next.prdata = {16'h0000, ctrl_word};
        ITRC_SEL_COUNT:   state_next.prdata = {16'h0000, state_reg.count};
        ITRC_SEL_STATUS:  state_next.prdata = {16'h0000, status_word};
        default:          state_next.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign prdata      = state_reg.prdata;
  assign pslverr     = psel && penable && state_reg.slverr;
  assign count_value = state_reg.count;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  logic tim_steady;
  assign tim_steady = (mode == ITRC_MODE_TIMER) && !stall && (state_reg.presc == 2'h0)
                      && !ctrl_we && !cnt_we;

  a_ctrl_reset_zero: assert property
    ($past(reset) |-> (ctrl_word == `ITRC_RST_CONTROL) && (state_reg.count == `ITRC_RST_COUNT))
    else $error("control not zero after reset");

  a_unimpl_read_zero: assert property
    ((setup_phase && !pwrite && setup_sel == ITRC_SEL_CONTROL)
     |=> ((prdata & ~{16'h0000, `ITRC_MASK_CONTROL}) == 32'h0000_0000))
    else $error("unimplemented control bits read nonzero");

  a_stop_holds_count: assert property
    ((!state_reg.run && !cnt_we) |=> $stable(state_reg.count))
    else $error("counter moved while stopped");

  a_idle_halt_holds: assert property
    ((state_reg.halt_idle && idle_mode && !cnt_we) ##1 (state_reg.halt_idle && idle_mode && !cnt_we)
     |=> $stable(state_reg.count) || $past(state_reg.post_sync[1]) || $past(presc_pulse))
    else $error("counter advanced in idle with halt set");

  a_step_by_one: assert property
    (!cnt_we |=> (state_reg.count == $past(state_reg.count))
                 || (state_reg.count == $past(state_reg.count) + 16'h0001))
    else $error("counter stepped by other than one");

  a_timer_full_rate: assert property
    (tim_steady [*2] |=> state_reg.count == $past(state_reg.count) + 16'h0001)
    else $error("timer mode 1:1 did not count each cycle");

  a_gate_closed: assert property
    ((mode == ITRC_MODE_GATED && !state_reg.gate_level) |-> !tick_in)
    else $error("gated timer counted with gate low");

  a_ext_ignored_int: assert property
    ((!state_reg.clk_src && !stall && gate_open) |-> tick_in)
    else $error("internal source not counting cycle clock");

  a_async_direct: assert property
    ((mode == ITRC_MODE_ASYNC && state_reg.run && presc_pulse && !cnt_we)
     |=> state_reg.count == $past(state_reg.count) + 16'h0001)
    else $error("async pulse not applied next cycle");

  a_sync_after_presc: assert property
    ((mode == ITRC_MODE_SYNC) [*3] |-> state_reg.post_sync[1] == $past(presc_pulse, 2))
    else $error("sync mode alignment not two cycles after prescaler");

  a_mode_from_write: assert property
    ((ctrl_we && pstrb[0])
     |=> mode == itrc_mode_type'({$past(pwdata[`ITRC_BIT_CLK_SRC]),
                                  $past(pwdata[`ITRC_BIT_CLK_SRC]) ? $past(pwdata[`ITRC_BIT_SYNC_SEL])
                                                                   : $past(pwdata[`ITRC_BIT_GATE_EN])}))
    else $error("mode does not follow written control bits");

  a_run_from_write: assert property
    ((ctrl_we && pstrb[1]) |=> state_reg.run == $past(pwdata[`ITRC_BIT_RUN]))
    else $error("run bit does not follow written control word");

  a_presc_from_write: assert property
    ((ctrl_we && pstrb[0])
     |=> state_reg.presc == $past(pwdata[`ITRC_BIT_PRESC_HI:`ITRC_BIT_PRESC_LO]))
    else $error("prescale select does not follow written control word");

  c_timer_counts: cover property (tim_steady [*3]);
  c_gated_counts: cover property (mode == ITRC_MODE_GATED && count_tick);
  c_sync_counts:  cover property (mode == ITRC_MODE_SYNC && count_tick);
  c_async_counts: cover property (mode == ITRC_MODE_ASYNC && count_tick);
  c_wrap:         cover property (count_tick && state_reg.count == 16'hFFFF);

endmodule
`default_nettype wire

// ==== testbench/itrc_ext_source.sv ====
// Purpose: Far side of the timer: external count clock source and gate driver.
// Assumes: Pin edges are launched just after a clk_sys edge.
// Notes:   The source clock stands still (low) outside a burst.
`timescale 1ns/1ps
`default_nettype none

module itrc_ext_source
#(
  parameter int HALF_PERIOD = 4
)
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Requests from the bench
  input  wire logic       start,
  input  wire logic [7:0] edges,
  input  wire logic       gate_request,
  // Pins toward the timer, busy flag to the bench
  output logic            count_pin,
  output logic            gate_pin,
  output logic            busy
);
  logic [7:0] left_q;
  logic [7:0] phase_q;

  // Slow oscillator: each level lasts HALF_PERIOD cycles, above the 3-cycle minimum
  always_ff @(posedge clk_sys)
  begin
    gate_pin <= reset ? 1'b0 : gate_request;
    if (reset)
    begin
      count_pin <= 1'b0;
      left_q    <= 8'h00;
      phase_q   <= 8'h00;
      busy      <= 1'b0;
    end
    else if (start && !busy)
    begin
      left_q  <= edges;
      phase_q <= 8'h00;
      busy    <= (edges != 8'h00);
    end
    else if (busy && phase_q == 8'(HALF_PERIOD - 1))
    begin
      phase_q   <= 8'h00;
      count_pin <= !count_pin;
      if (!count_pin)
        left_q <= left_q - 8'h01;
      else if (left_q == 8'h00)
        busy <= 1'b0;
    end
    else if (busy)
      phase_q <= phase_q + 8'h01;
  end
endmodule

`default_nettype wire

// ==== testbench/itrc_timer_tb.sv ====
// Purpose: Self-checking bench of the interval timer over APB.
// Assumes: Zero-wait APB slave; external source model on the pins.
// Notes:   Intervals and counts are measured on count_value; registers and the stopped count are read over APB.
`timescale 1ns/1ps
`default_nettype none
`include "itrc_defs.svh"

module itrc_timer_tb;
  import itrc_pkg::*;
  logic          clk_sys;
  logic          reset;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [11:0]   paddr;
  logic [31:0]   pwdata;
  logic [3:0]    pstrb;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          idle_mode;
  logic          start;
  logic          gate_request;
  logic [7:0]    edges;
  logic          count_pin;
  logic          gate_pin;
  logic          busy;
  itrc_mode_type mode;
  logic [15:0]   count_value;
  logic [15:0]   prev;
  logic [31:0]   rd;
  logic          err;
  int            mismatches;
  int            checks;
  int            n;
  int            a;
  logic [15:0]   ctl_tab [6] = '{16'h0000, 16'h0004, 16'h0040, 16'h0046, 16'h0006, 16'h0002};
  itrc_mode_type mode_tab [6] = '{ITRC_MODE_TIMER, ITRC_MODE_TIMER, ITRC_MODE_GATED,
                                  ITRC_MODE_SYNC, ITRC_MODE_SYNC, ITRC_MODE_ASYNC};
  int            ratio [4] = '{1, 8, 64, 256};

  itrc_timer i_itrc_timer (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_pin(count_pin), .gate_pin(gate_pin),
    .idle_mode(idle_mode), .mode(mode), .count_value(count_value));

  itrc_ext_source i_itrc_ext_source (.clk_sys(clk_sys), .reset(reset), .start(start),
    .edges(edges), .gate_request(gate_request), .count_pin(count_pin), .gate_pin(gate_pin),
    .busy(busy));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Held from setup until pready is seen high; data taken at that same edge
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= data;
    pstrb   <= 4'hF;
    @(posedge clk_sys);
    penable <= 1'b1;
    // No wait-state count assumed; only the watchdog ends a stuck transfer
    do
    begin
      @(posedge clk_sys);
    end
    while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_change(input int limit);
    logic [15:0] old;
    old = count_value;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (count_value === old && n < limit);
    if (count_value === old)
    begin
      $display("mismatch count change expected change seen %h", old);
      mismatches++;
    end
  endtask

  task automatic ext_edges(input logic [7:0] e);
    @(posedge clk_sys);
    edges <= e;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    wait_change(200);
    while (busy === 1'b1)
    begin
      @(posedge clk_sys);
    end
    repeat (10) @(posedge clk_sys);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the sequence needs well under 10000 cycles
  initial
  begin
    repeat (50000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end

  initial
  begin
    {reset, psel, penable, pwrite, idle_mode, start, gate_request} = 7'h40;
    {paddr, pwdata, pstrb, edges} = '0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, `ITRC_OFS_CONTROL, 32'h0);
    check("control reset", 32'h0, rd);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h0000FFFF);
    apb(1'b0, `ITRC_OFS_CONTROL, 32'h0);
    check("control mask", 32'h0000A076, rd);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    check("unmapped error", 32'h1, {31'h0, err});
    check("unmapped data", 32'h0, rd);
    for (a = 0; a < 6; a++)
    begin
      apb(1'b1, `ITRC_OFS_CONTROL, {16'h0, ctl_tab[a]});
      apb(1'b0, `ITRC_OFS_STATUS, 32'h0);
      check("mode", {30'h0, mode_tab[a]}, {30'h0, mode});
      check("status mode", {30'h0, mode_tab[a]}, {30'h0, rd[1:0]});
    end
    for (a = 0; a < 4; a++)
    begin
      // First gap after a ratio change is one cycle longer; measure a later one
      apb(1'b1, `ITRC_OFS_CONTROL, 32'h8000 | (a << 4));
      wait_change(600);
      wait_change(600);
      wait_change(600);
      check("prescale interval", ratio[a], n);
    end
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h0);
    repeat (4) @(posedge clk_sys);
    prev = count_value;
    repeat (30) @(posedge clk_sys);
    apb(1'b0, `ITRC_OFS_COUNT, 32'h0);
    check("stopped count", {16'h0, prev}, rd);
    apb(1'b1, `ITRC_OFS_COUNT, 32'hFFFE);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8000);
    wait_change(10);
    check("count top", 32'hFFFF, {16'h0, count_value});
    wait_change(10);
    check("count wrap", 32'h0, {16'h0, count_value});
    @(posedge clk_sys);
    idle_mode <= 1'b1;
    apb(1'b1, `ITRC_OFS_CONTROL, 32'hA000);
    repeat (4) @(posedge clk_sys);
    prev = count_value;
    repeat (30) @(posedge clk_sys);
    check("idle halted", {16'h0, prev}, {16'h0, count_value});
    apb(1'b0, `ITRC_OFS_STATUS, 32'h0);
    check("idle status", 32'h0, {31'h0, rd[2]});
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8000);
    wait_change(10);
    check("idle counting", 32'h1, {31'h0, n < 10});
    idle_mode <= 1'b0;
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h0);
    apb(1'b1, `ITRC_OFS_COUNT, 32'h0);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8040);
    repeat (20) @(posedge clk_sys);
    check("gate closed", 32'h0, {16'h0, count_value});
    gate_request <= 1'b1;
    repeat (40) @(posedge clk_sys);
    gate_request <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check("gated time", 32'h1, {31'h0, count_value >= 38 && count_value <= 42});
    apb(1'b1, `ITRC_OFS_COUNT, 32'h0);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8002);
    ext_edges(8'd12);
    check("async edges", 32'd12, {16'h0, count_value});
    apb(1'b1, `ITRC_OFS_COUNT, 32'h0);
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8016);
    ext_edges(8'd16);
    check("sync prescaled edges", 32'd2, {16'h0, count_value});
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8002);
    ext_edges(8'd1);
    a = n;
    apb(1'b1, `ITRC_OFS_CONTROL, 32'h8006);
    ext_edges(8'd1);
    check("sync extra delay", `ITRC_POST_SYNC, n - a);
    stop_test();
  end
endmodule

`default_nettype wire
